/* rtl/dsimd_datapath.sv */
// Purpose: two lockstep processing elements, register files, bus
//   transfer paths and a selective instruction cache
// Assumes: all inputs synchronous to clk; sequencer retries stalls
// Notes: results land in the register file at the next clk edge
//
// Contract
// - The primary element always runs; the secondary runs only while second_element_enable is set.
// - With the secondary enabled each instruction executes in both elements on their own data.
// - Dual operation doubles memory to element transfer bandwidth.
// - In dual operation each transfer moves two values, one per element.
// - ALU, multiplier and shifter each finish in one cycle; the multiplier works in parallel with the ALU or the shifter, which share one result port.
// - One multifunction instruction runs an ALU and a multiplier operation together.
// - In dual operation that ALU and multiplier pair runs in both elements.
// - The multiplier handles single precision float, 40-bit float and 32-bit fixed data; ALU add and subtract and the shifter work on 32-bit fixed data.
// - Each element has a 32 register file, 16 primary and 16 secondary.
// - The data_memory_bus carries data only; program_memory_bus carries code and data.
// - One cycle can move four operands plus one cached instruction.
// - Only instructions whose fetch collided with a program bus data access are cached.
`default_nettype none
module dsimd_datapath (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // mode
  input wire logic [31:0] mode_control_word_1,
  // instruction
  input wire logic ins_valid,
  input wire dsimd_pkg::dsimd_alu_t alu_op,
  input wire dsimd_pkg::dsimd_shf_t shf_op,
  input wire logic mul_en,
  input wire dsimd_pkg::dsimd_fmt_t fmt,
  input wire logic [3:0] src_a,
  input wire logic [3:0] src_b,
  input wire logic [3:0] dst_alu,
  input wire logic [3:0] dst_mul,
  // data_memory_bus
  input wire logic dm_ld,
  input wire logic dm_st,
  input wire logic [3:0] dm_reg,
  input wire logic [39:0] dm_rd_x,
  input wire logic [39:0] dm_rd_y,
  output logic [39:0] dm_wr_x,
  output logic [39:0] dm_wr_y,
  output logic dm_wr_vx,
  output logic dm_wr_vy,
  // program_memory_bus data
  input wire logic pm_ld,
  input wire logic pm_st,
  input wire logic [3:0] pm_reg,
  input wire logic [39:0] pm_rd_x,
  input wire logic [39:0] pm_rd_y,
  output logic [39:0] pm_wr_x,
  output logic [39:0] pm_wr_y,
  output logic pm_wr_vx,
  output logic pm_wr_vy,
  // instruction fetch
  input wire logic fetch_req,
  input wire logic [23:0] fetch_addr,
  input wire logic [47:0] pm_instr,
  output logic [47:0] fetch_instr,
  output logic fetch_valid,
  output logic fetch_stall
);
  // ***********************
  // unit functions
  // ***********************
  function automatic logic [39:0] f_alu(dsimd_pkg::dsimd_alu_t op,
                                        logic [39:0] a, logic [39:0] b);
    case (op)
      dsimd_pkg::ALU_ADD: f_alu = {a[39:8] + b[39:8], 8'h00};
      dsimd_pkg::ALU_SUB: f_alu = {a[39:8] - b[39:8], 8'h00};
      dsimd_pkg::ALU_AND: f_alu = a & b;
      dsimd_pkg::ALU_OR: f_alu = a | b;
      dsimd_pkg::ALU_FABS: f_alu = {1'b0, a[38:0]};
      dsimd_pkg::ALU_FNEG: f_alu = {~a[39], a[38:0]};
      default: f_alu = a;
    endcase
  endfunction

  function automatic logic [39:0] f_shf(dsimd_pkg::dsimd_shf_t op,
                                        logic [39:0] a, logic [39:0] b);
    logic [31:0] x;
    logic [5:0] n;
    x = a[39:8];
    n = b[13:8];
    case (op)
      dsimd_pkg::SHF_LSL: f_shf = {x << n, 8'h00};
      dsimd_pkg::SHF_LSR: f_shf = {x >> n, 8'h00};
      dsimd_pkg::SHF_ASR: f_shf = {32'($signed(x) >>> n), 8'h00};
      default: f_shf = a;
    endcase
  endfunction

  // float: sign 39, exponent 38:31, mantissa 30:0
  function automatic logic [39:0] f_mul(dsimd_pkg::dsimd_fmt_t fm,
                                        logic [39:0] a, logic [39:0] b);
    logic [63:0] p;
    logic [9:0] e;
    logic [30:0] m;
    logic s;
    logic [39:0] r;
    s = a[39] ^ b[39];
    if (fm == dsimd_pkg::FMT_FIX32) begin
      p = 64'($signed(a[39:8]) * $signed(b[39:8]));
      r = {p[31:0], 8'h00};
    end else begin
      p = {1'b1, a[30:0]} * {1'b1, b[30:0]};
      e = {2'b00, a[38:31]} + {2'b00, b[38:31]} - dsimd_pkg::EXP_BIAS;
      if (p[63]) begin
        m = p[62:32];
        e = e + 10'h001;
      end else begin
        m = p[61:31];
      end
      if (a[38:31] == 8'h00 || b[38:31] == 8'h00 || e[9])
        r = {s, 39'h0};
      else if (e[8] || e[7:0] == dsimd_pkg::EXP_MAX)
        r = {s, dsimd_pkg::EXP_MAX, 31'h0};
      else
        r = {s, e[7:0], m};
      if (fm == dsimd_pkg::FMT_FLT32)
        r[7:0] = 8'h00;
    end
    f_mul = r;
  endfunction

  // ***********************
  // element datapath
  // ***********************
  logic [39:0] rfx_reg [dsimd_pkg::RNUM];
  logic [39:0] rfy_reg [dsimd_pkg::RNUM];
  logic [39:0] rfx_next [dsimd_pkg::RNUM];
  logic [39:0] rfy_next [dsimd_pkg::RNUM];
  logic simd, bank;
  logic [4:0] ia, ib, wa, wm, wd, wp;
  logic [39:0] alux, aluy, mulx, muly;
  logic we_alu, we_mul, ld_any;

  assign simd = mode_control_word_1[dsimd_pkg::MODE_PEN_BIT];
  assign bank = mode_control_word_1[dsimd_pkg::MODE_BANK_BIT];
  assign ia = {bank, src_a};
  assign ib = {bank, src_b};
  assign wa = {bank, dst_alu};
  assign wm = {bank, dst_mul};
  assign wd = {bank, dm_reg};
  assign wp = {bank, pm_reg};
  assign ld_any = dm_ld | pm_ld;

  always_comb begin
    // alu and shifter share a port, multiplier alongside
    we_alu = ins_valid && (alu_op != dsimd_pkg::ALU_NOP ||
                           shf_op != dsimd_pkg::SHF_NONE);
    we_mul = ins_valid && mul_en;
    alux = (alu_op != dsimd_pkg::ALU_NOP) ?
           f_alu(alu_op, rfx_reg[ia], rfx_reg[ib]) :
           f_shf(shf_op, rfx_reg[ia], rfx_reg[ib]);
    aluy = (alu_op != dsimd_pkg::ALU_NOP) ?
           f_alu(alu_op, rfy_reg[ia], rfy_reg[ib]) :
           f_shf(shf_op, rfy_reg[ia], rfy_reg[ib]);
    mulx = f_mul(fmt, rfx_reg[ia], rfx_reg[ib]);
    muly = f_mul(fmt, rfy_reg[ia], rfy_reg[ib]);
  end

  always_comb begin
    rfx_next = rfx_reg;
    rfy_next = rfy_reg;
    if (we_alu) begin
      rfx_next[wa] = alux;
      if (simd)
        rfy_next[wa] = aluy;
    end
    if (we_mul) begin
      rfx_next[wm] = mulx;
      if (simd)
        rfy_next[wm] = muly;
    end
    // bus loads win over results aimed at the same register
    if (dm_ld) begin
      rfx_next[wd] = dm_rd_x;
      if (simd)
        rfy_next[wd] = dm_rd_y;
    end
    if (pm_ld) begin
      rfx_next[wp] = pm_rd_x;
      if (simd)
        rfy_next[wp] = pm_rd_y;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < dsimd_pkg::RNUM; i++) begin
        rfx_reg[i] <= dsimd_pkg::REG_RST;
        rfy_reg[i] <= dsimd_pkg::REG_RST;
      end
    end else begin
      rfx_reg <= rfx_next;
      rfy_reg <= rfy_next;
    end
  end

  // ***********************
  // bus stores
  // ***********************
  logic [39:0] dm_wr_x_next, dm_wr_y_next, pm_wr_x_next, pm_wr_y_next;
  logic dm_wr_vx_next, dm_wr_vy_next, pm_wr_vx_next, pm_wr_vy_next;

  always_comb begin
    dm_wr_vx_next = dm_st;
    dm_wr_vy_next = dm_st && simd;
    dm_wr_x_next = dm_st ? rfx_reg[wd] : dm_wr_x;
    dm_wr_y_next = dm_wr_vy_next ? rfy_reg[wd] : dm_wr_y;
    pm_wr_vx_next = pm_st;
    pm_wr_vy_next = pm_st && simd;
    pm_wr_x_next = pm_st ? rfx_reg[wp] : pm_wr_x;
    pm_wr_y_next = pm_wr_vy_next ? rfy_reg[wp] : pm_wr_y;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dm_wr_x <= dsimd_pkg::REG_RST;
      dm_wr_y <= dsimd_pkg::REG_RST;
      dm_wr_vx <= 1'b0;
      dm_wr_vy <= 1'b0;
      pm_wr_x <= dsimd_pkg::REG_RST;
      pm_wr_y <= dsimd_pkg::REG_RST;
      pm_wr_vx <= 1'b0;
      pm_wr_vy <= 1'b0;
    end else begin
      dm_wr_x <= dm_wr_x_next;
      dm_wr_y <= dm_wr_y_next;
      dm_wr_vx <= dm_wr_vx_next;
      dm_wr_vy <= dm_wr_vy_next;
      pm_wr_x <= pm_wr_x_next;
      pm_wr_y <= pm_wr_y_next;
      pm_wr_vx <= pm_wr_vx_next;
      pm_wr_vy <= pm_wr_vy_next;
    end
  end

  // ***********************
  // selective instruction cache
  // ***********************
  logic [47:0] c_dat_reg [dsimd_pkg::CDEPTH];
  logic [19:0] c_tag_reg [dsimd_pkg::CDEPTH];
  logic [15:0] c_vld_reg;
  dsimd_pkg::dsimd_cst_t cst_reg, cst_next;
  logic [23:0] pend_reg, pend_next;
  logic [47:0] fetch_instr_next;
  logic fetch_valid_next, fetch_stall_next;
  logic coll, hit, c_we;
  logic [3:0] ci;

  // only the program bus competes with instruction fetch
  assign coll = fetch_req && (pm_ld || pm_st);
  assign ci = fetch_addr[3:0];
  assign hit = c_vld_reg[ci] && c_tag_reg[ci] == fetch_addr[23:4];

  always_comb begin
    cst_next = cst_reg;
    pend_next = pend_reg;
    fetch_instr_next = fetch_instr;
    fetch_valid_next = 1'b0;
    fetch_stall_next = 1'b0;
    c_we = 1'b0;
    case (cst_reg)
      dsimd_pkg::C_IDLE,
      dsimd_pkg::C_PEND: begin
        if (fetch_req && !coll) begin
          fetch_instr_next = pm_instr;
          fetch_valid_next = 1'b1;
          if (cst_reg == dsimd_pkg::C_PEND && fetch_addr == pend_reg) begin
            c_we = 1'b1;
            cst_next = dsimd_pkg::C_IDLE;
          end
        end else if (coll && hit) begin
          fetch_instr_next = c_dat_reg[ci];
          fetch_valid_next = 1'b1;
        end else if (coll) begin
          fetch_stall_next = 1'b1;
          cst_next = dsimd_pkg::C_PEND;
          pend_next = fetch_addr;
        end
      end
      default: cst_next = dsimd_pkg::C_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cst_reg <= dsimd_pkg::C_IDLE;
      pend_reg <= dsimd_pkg::ADR_RST;
      fetch_instr <= dsimd_pkg::INS_RST;
      fetch_valid <= 1'b0;
      fetch_stall <= 1'b0;
      c_vld_reg <= 16'h0000;
      for (int i = 0; i < dsimd_pkg::CDEPTH; i++) begin
        c_dat_reg[i] <= dsimd_pkg::INS_RST;
        c_tag_reg[i] <= 20'h00000;
      end
    end else begin
      cst_reg <= cst_next;
      pend_reg <= pend_next;
      fetch_instr <= fetch_instr_next;
      fetch_valid <= fetch_valid_next;
      fetch_stall <= fetch_stall_next;
      if (c_we) begin
        c_vld_reg[ci] <= 1'b1;
        c_dat_reg[ci] <= pm_instr;
        c_tag_reg[ci] <= fetch_addr[23:4];
      end
    end
  end

  // ***********************
  // checks
  // ***********************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_miss;
    fetch_req && coll && !hit;
  endsequence
  sequence s_refill;
    fetch_req && !coll && cst_reg == dsimd_pkg::C_PEND &&
      fetch_addr == pend_reg;
  endsequence
  sequence s_recoll;
    fetch_req && coll && fetch_addr == $past(fetch_addr);
  endsequence

  property p_y_idle;
    !simd && we_alu |=> rfy_reg[$past(wa)] == $past(rfy_reg[wa]);
  endproperty
  a_y_idle: assert property (p_y_idle)
    else $error("disabled secondary register changed");

  property p_both;
    simd && we_alu && !ld_any && !(we_mul && wm == wa) |=>
      rfx_reg[$past(wa)] == $past(alux) &&
      rfy_reg[$past(wa)] == $past(aluy);
  endproperty
  a_both: assert property (p_both)
    else $error("alu result missing in an element");

  property p_mul_par;
    simd && we_alu && we_mul && wa != wm && !ld_any |=>
      rfx_reg[$past(wm)] == $past(mulx) &&
      rfy_reg[$past(wm)] == $past(muly) &&
      rfy_reg[$past(wa)] == $past(aluy);
  endproperty
  a_mul_par: assert property (p_mul_par)
    else $error("multifunction pair incomplete");

  property p_dm_dual;
    dm_st && simd |=> dm_wr_vx && dm_wr_vy &&
      dm_wr_y == $past(rfy_reg[wd]);
  endproperty
  a_dm_dual: assert property (p_dm_dual)
    else $error("dual store lost second value");

  property p_sisd_bw;
    (dm_st || pm_st) && !simd |=> !dm_wr_vy && !pm_wr_vy;
  endproperty
  a_sisd_bw: assert property (p_sisd_bw)
    else $error("single element moved two values");

  property p_fetch_pm;
    fetch_req && !coll |=> fetch_valid && fetch_instr == $past(pm_instr);
  endproperty
  a_fetch_pm: assert property (p_fetch_pm)
    else $error("program bus fetch not delivered");

  property p_only_coll;
    c_we |-> cst_reg == dsimd_pkg::C_PEND && fetch_addr == pend_reg;
  endproperty
  a_only_coll: assert property (p_only_coll)
    else $error("cache filled without collision");

  property p_refetch;
    s_miss ##1 s_refill ##1 s_recoll |=> fetch_valid && !fetch_stall;
  endproperty
  a_refetch: assert property (p_refetch)
    else $error("collided instruction not cached");

  property p_hit;
    fetch_req && coll && hit |=> fetch_valid && !fetch_stall &&
      fetch_instr == $past(c_dat_reg[ci]);
  endproperty
  a_hit: assert property (p_hit)
    else $error("cache hit not served");

  // a second collided miss may follow at once and stall again
  property p_stall;
    s_miss |=> fetch_stall && !fetch_valid ##1
      (!fetch_stall || $past(coll));
  endproperty
  a_stall: assert property (p_stall)
    else $error("collision miss not stalled");
endmodule
`default_nettype wire

/* rtl/dsimd_pkg.sv */
// Purpose: shared constants and types of the dual element datapath
// Assumes: one 10 MHz core clock, asynchronous active high reset
// Notes: words are 40 bits; 32-bit data sits in bits 39:8
`default_nettype none
package dsimd_pkg;
  localparam int DW = 40;
  localparam int RBITS = 4;
  localparam int RNUM = 32;
  localparam int IW = 48;
  localparam int AW = 24;
  localparam int CBITS = 4;
  localparam int CDEPTH = 16;
  // mode_control_word_1 field positions
  localparam int MODE_PEN_BIT = 21;
  localparam int MODE_BANK_BIT = 10;
  // reset values
  localparam logic [39:0] REG_RST = 40'h0;
  localparam logic [47:0] INS_RST = 48'h0;
  localparam logic [23:0] ADR_RST = 24'h0;
  // float field values
  localparam logic [9:0] EXP_BIAS = 10'h07f;
  localparam logic [7:0] EXP_MAX = 8'hff;
  typedef enum logic [2:0] {
    ALU_NOP, ALU_ADD, ALU_SUB, ALU_AND,
    ALU_OR, ALU_PASS, ALU_FABS, ALU_FNEG
  } dsimd_alu_t;
  typedef enum logic [1:0] {
    SHF_NONE, SHF_LSL, SHF_LSR, SHF_ASR
  } dsimd_shf_t;
  typedef enum logic [1:0] {
    FMT_FIX32, FMT_FLT32, FMT_FLT40, FMT_RSVD
  } dsimd_fmt_t;
  typedef enum logic {C_IDLE, C_PEND} dsimd_cst_t;
endpackage
`default_nettype wire

/* tb/dsimd_mem_model.sv */
// Purpose: memory and sequencer side seen by the datapath
// Assumes: word arrays are filled by the bench before any load
// Notes: an idle bus shows a pattern that changes every cycle
`default_nettype none
module dsimd_mem_model (
  // clock
  input wire logic clk,
  // requests
  input wire logic d_ld,
  input wire logic [3:0] d_reg,
  input wire logic p_ld,
  input wire logic p_st,
  input wire logic [3:0] p_reg,
  input wire logic [23:0] faddr,
  // answers
  output logic [39:0] d_x,
  output logic [39:0] d_y,
  output logic [39:0] p_x,
  output logic [39:0] p_y,
  output logic [47:0] instr
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // word sources
  // ****************************************
  logic [39:0] mx [16];
  logic [39:0] my [16];
  logic [47:0] junk = 48'h0;
  always @(posedge clk) junk <= ~junk + 48'h9e3779b9;
  assign d_x = d_ld ? mx[d_reg] : junk[39:0];
  assign d_y = d_ld ? my[d_reg] : ~junk[39:0];
  assign p_x = p_ld ? mx[p_reg ^ 4'hf] : junk[47:8];
  assign p_y = p_ld ? my[p_reg ^ 4'hf] : ~junk[47:8];
  // fetch word only while the program bus carries no data
  assign instr = (p_ld | p_st) ? junk : {faddr, ~faddr};
endmodule
`default_nettype wire

/* tb/dual_element_simd_datapath_bench.sv */
// Purpose: self-checking bench of the dual element datapath
// Assumes: reference registers track both element files
// Notes: fixed data except one float multiply test, low 8 bits of every word zero
`default_nettype none
module dual_element_simd_datapath_bench;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // signals
  // ****************************************
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [31:0] mode_control_word_1 = 32'h0;
  logic ins_valid = 1'b0;
  dsimd_pkg::dsimd_alu_t alu_op = dsimd_pkg::ALU_NOP;
  dsimd_pkg::dsimd_shf_t shf_op = dsimd_pkg::SHF_LSL;
  dsimd_pkg::dsimd_fmt_t fmt = dsimd_pkg::FMT_FIX32;
  logic mul_en = 1'b0;
  logic [3:0] src_a = 4'h0, src_b = 4'h0, dst_alu = 4'h0, dst_mul = 4'h0;
  logic dm_ld = 1'b0, dm_st = 1'b0, pm_ld = 1'b0, pm_st = 1'b0;
  logic [3:0] dm_reg = 4'h0, pm_reg = 4'h0;
  logic fetch_req = 1'b0;
  logic [23:0] fetch_addr = 24'h0;
  logic [39:0] dm_rd_x, dm_rd_y, pm_rd_x, pm_rd_y;
  logic [39:0] dm_wr_x, dm_wr_y, pm_wr_x, pm_wr_y;
  logic dm_wr_vx, dm_wr_vy, pm_wr_vx, pm_wr_vy;
  logic [47:0] pm_instr, fetch_instr;
  logic fetch_valid, fetch_stall;
  logic [39:0] rx [32];
  logic [39:0] ry [32];
  logic dual, bank;
  int n_fail = 0;
  int checked = 0;
  // float words: sign 39, exponent 38:31, mantissa 30:0
  localparam logic [39:0] FL_TWO = 40'h4000000000;
  localparam logic [39:0] FL_THREE = 40'h4040000000;
  localparam logic [39:0] FL_SIX = 40'h40c0000000;

  always #50 clk = ~clk;

  dsimd_datapath i_dut (
    .clk, .rst, .mode_control_word_1, .ins_valid, .alu_op, .shf_op,
    .mul_en, .fmt, .src_a, .src_b, .dst_alu, .dst_mul,
    .dm_ld, .dm_st, .dm_reg, .dm_rd_x, .dm_rd_y, .dm_wr_x, .dm_wr_y,
    .dm_wr_vx, .dm_wr_vy, .pm_ld, .pm_st, .pm_reg, .pm_rd_x, .pm_rd_y,
    .pm_wr_x, .pm_wr_y, .pm_wr_vx, .pm_wr_vy, .fetch_req, .fetch_addr,
    .pm_instr, .fetch_instr, .fetch_valid, .fetch_stall
  );

  dsimd_mem_model i_mem (
    .clk, .d_ld(dm_ld), .d_reg(dm_reg), .p_ld(pm_ld), .p_st(pm_st),
    .p_reg(pm_reg), .faddr(fetch_addr), .d_x(dm_rd_x), .d_y(dm_rd_y),
    .p_x(pm_rd_x), .p_y(pm_rd_y), .instr(pm_instr)
  );

  // ****************************************
  // helpers
  // ****************************************
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [47:0] exp,
      input logic [47:0] got);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tick();
    @(posedge clk);
    #1;
  endtask

  function automatic logic [39:0] alu_ref(dsimd_pkg::dsimd_alu_t op,
      logic [39:0] a, logic [39:0] b);
    case (op)
      dsimd_pkg::ALU_ADD: return {a[39:8] + b[39:8], 8'h00};
      dsimd_pkg::ALU_SUB: return {a[39:8] - b[39:8], 8'h00};
      dsimd_pkg::ALU_AND: return a & b;
      dsimd_pkg::ALU_OR: return a | b;
      dsimd_pkg::ALU_FABS: return {1'b0, a[38:0]};
      dsimd_pkg::ALU_FNEG: return {~a[39], a[38:0]};
      dsimd_pkg::ALU_NOP:
        case (shf_op)
          dsimd_pkg::SHF_LSL: return {a[39:8] << b[13:8], 8'h00};
          dsimd_pkg::SHF_LSR: return {a[39:8] >> b[13:8], 8'h00};
          dsimd_pkg::SHF_ASR:
            return {32'($signed(a[39:8]) >>> b[13:8]), 8'h00};
          default: return a;
        endcase
      default: return a;
    endcase
  endfunction

  function automatic logic [39:0] mul_ref(logic [39:0] a, logic [39:0] b);
    logic signed [63:0] p;
    p = $signed(a[39:8]) * $signed(b[39:8]);
    return {p[31:0], 8'h00};
  endfunction

  task automatic set_mode(input logic d, input logic b);
    logic [31:0] w;
    w = 32'h0;
    w[dsimd_pkg::MODE_PEN_BIT] = d;
    w[dsimd_pkg::MODE_BANK_BIT] = b;
    dual = d;
    bank = b;
    mode_control_word_1 = w;
  endtask

  // every request strobe set once per cycle, never cleared then reset
  task automatic drive_ctl(input logic [6:0] s);
    {ins_valid, mul_en, dm_ld, dm_st, pm_ld, pm_st, fetch_req} = s;
  endtask

  // both buses load in one cycle
  task automatic load(input logic [3:0] a, input logic [3:0] b);
    drive_ctl(7'h14);
    {dm_reg, pm_reg} = {a, b};
    tick();
    rx[{bank, a}] = i_mem.mx[a];
    if (dual) ry[{bank, a}] = i_mem.my[a];
    rx[{bank, b}] = i_mem.mx[b ^ 4'hf];
    if (dual) ry[{bank, b}] = i_mem.my[b ^ 4'hf];
  endtask

  task automatic store(input logic [3:0] a, input logic [3:0] b);
    drive_ctl(7'h0a);
    {dm_reg, pm_reg} = {a, b};
    tick();
    chk("dm_wr_vx", 1'b1, dm_wr_vx);
    chk("dm_wr_x", rx[{bank, a}], dm_wr_x);
    chk("dm_wr_vy", dual, dm_wr_vy);
    chk("pm_wr_vx", 1'b1, pm_wr_vx);
    chk("pm_wr_x", rx[{bank, b}], pm_wr_x);
    chk("pm_wr_vy", dual, pm_wr_vy);
    if (dual) begin
      chk("dm_wr_y", ry[{bank, a}], dm_wr_y);
      chk("pm_wr_y", ry[{bank, b}], pm_wr_y);
    end
  endtask

  task automatic exec(input int op, input logic [3:0] a, b, d, m,
      input logic me);
    logic [39:0] xa, xb, ya, yb;
    {xa, xb} = {rx[{bank, a}], rx[{bank, b}]};
    {ya, yb} = {ry[{bank, a}], ry[{bank, b}]};
    drive_ctl({1'b1, me, 5'h00});
    alu_op = dsimd_pkg::dsimd_alu_t'(op);
    {src_a, src_b, dst_alu, dst_mul} = {a, b, d, m};
    tick();
    // no alu and no shift means no write
    if (alu_op != dsimd_pkg::ALU_NOP || shf_op != dsimd_pkg::SHF_NONE) begin
      rx[{bank, d}] = alu_ref(alu_op, xa, xb);
      if (dual) ry[{bank, d}] = alu_ref(alu_op, ya, yb);
    end
    if (me) rx[{bank, m}] = mul_ref(xa, xb);
    if (dual && me) ry[{bank, m}] = mul_ref(ya, yb);
  endtask

  task automatic fetch(input logic [23:0] ad, input logic col,
      input logic miss);
    drive_ctl({5'h00, col, 1'b1});
    {fetch_addr, pm_reg} = {ad, 4'h0};
    tick();
    chk("fetch_stall", miss, fetch_stall);
    chk("fetch_valid", !miss, fetch_valid);
    if (!miss) chk("fetch_instr", {ad, ~ad}, fetch_instr);
  endtask

  // ****************************************
  // tests
  // ****************************************
  initial begin
    #(100 * 10000);
    n_fail++;
    report_and_stop();
  end

  initial begin
    logic [3:0] a, b, d, m;
    logic [23:0] fa;
    void'($urandom(29));
    for (int r = 0; r < 32; r++) begin
      rx[r] = 40'h0;
      ry[r] = 40'h0;
    end
    set_mode(1'b0, 1'b0);
    repeat (12) @(posedge clk);
    #1;
    rst = 1'b0;
    chk("fetch_valid", 1'b0, fetch_valid);
    chk("dm_wr_vx", 1'b0, dm_wr_vx);
    for (int k = 0; k < 64; k++) begin
      for (int r = 0; r < 16; r++) begin
        i_mem.mx[r] = {32'($urandom), 8'h00};
        i_mem.my[r] = {32'($urandom), 8'h00};
      end
      set_mode(1'($urandom), 1'($urandom));
      shf_op = dsimd_pkg::dsimd_shf_t'(k[5:4]);
      {a, b, d, m} = 16'($urandom);
      load(a, b);
      load(d, m);
      exec(k % 8, a, b, d, m, k[3]);
      exec(7 - k % 8, d, m, b, a, ~k[3]);
      store(b, d);
      store(a, m);
    end
    // float multiply 2.0 by 3.0 in both float formats, both elements
    for (int f = 1; f < 3; f++) begin
      set_mode(1'b1, f[0]);
      i_mem.mx[1] = FL_TWO;
      i_mem.my[1] = FL_THREE;
      i_mem.mx[2] = FL_THREE;
      i_mem.my[2] = FL_TWO;
      load(4'h1, 4'hd);
      fmt = dsimd_pkg::dsimd_fmt_t'(f);
      exec(5, 4'h1, 4'hd, 4'h3, 4'h4, 1'b1);
      rx[{bank, 4'h4}] = FL_SIX;
      ry[{bank, 4'h4}] = FL_SIX;
      store(4'h4, 4'h3);
    end
    fmt = dsimd_pkg::FMT_FIX32;
    for (int k = 0; k < 4; k++) begin
      fa = 24'($urandom);
      fetch(fa, 1'b1, 1'b1);
      fetch(fa, 1'b0, 1'b0);
      fetch(fa, 1'b1, 1'b0);
      fetch(fa ^ 24'h000010, 1'b0, 1'b0);
      fetch(fa ^ 24'h000010, 1'b1, 1'b1);
      fetch(fa, 1'b1, 1'b0);
    end
    report_and_stop();
  end
endmodule
`default_nettype wire
